// ---- design/ebl_consts.svh ----
`ifndef EBL_CONSTS_SVH
`define EBL_CONSTS_SVH
// ----------------------------------------
// Address split and bus widths
// ----------------------------------------
`define EBL_ADDR_W      26
`define EBL_PIN_ADDR_W  13
`define EBL_LO_MSB      12
`define EBL_HI_LSB      13
`define EBL_HI_MSB      25
`define EBL_DATA_W      32
// ----------------------------------------
// Cycle timing in bus clocks
// ----------------------------------------
`define EBL_ALE_CYC     4'h2
`define EBL_GAP_CYC     4'h1
`define EBL_TURN_CYC    4'h1
`define EBL_STROBE_CYC  4'h3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EBL_DATA_RST    32'h0000_0000
`endif

// ---- design/ebl_pkg.sv ----
package ebl_pkg;
  // Kind of device behind the access
  typedef enum logic [2:0] {
    EBL_PORT_STATIC32 = 3'h0,
    EBL_PORT_STATIC16 = 3'h1,
    EBL_PORT_DRAM16   = 3'h2,
    EBL_PORT_SDRAM16  = 3'h3,
    EBL_PORT_SDRAM8   = 3'h4,
    EBL_PORT_INTERNAL = 3'h5
  } ebl_port_t;

  // Select space that decoded the access
  typedef enum logic [1:0] {
    EBL_SP_MEM  = 2'h0,
    EBL_SP_GEN  = 2'h1,
    EBL_SP_CARD = 2'h2,
    EBL_SP_NONE = 2'h3
  } ebl_space_t;

  // One request from the bus interface
  typedef struct packed {
    logic        write;
    ebl_port_t   port;
    ebl_space_t  space;
    logic [1:0]  sel;
    logic        card_attr;
    logic [25:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [12:0] row;
    logic [12:0] col;
  } ebl_req_t;

  // Pin bundle driven out
  typedef struct packed {
    logic [12:0] addr;
    logic        ale;
    logic        rd_n;
    logic        we_n;
    logic [3:0]  cbs_n;
    logic [3:0]  msel_n;
    logic [3:0]  gsel_n;
    logic        card1_n;
    logic        card2_n;
    logic        reg_n;
    logic [31:0] dout;
    logic        doe_n;
  } ebl_pins_t;
endpackage

// ---- design/ebl_lane_steer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ebl_consts.svh"
module ebl_lane_steer
  import ebl_pkg::*;
(
  input  wire logic        big_endian,  // Sampled byte order
  input  wire ebl_port_t   port,        // Port kind
  input  wire logic [1:0]  low_addr,    // Byte address bits
  input  wire logic [3:0]  be_in,       // Logical byte enables
  input  wire logic [31:0] data_in,     // Logical write data
  input  wire logic [31:0] pin_data,    // Data from pins
  output logic      [3:0]  be_out,      // Pin lane enables
  output logic      [31:0] data_out,    // Pin lane data
  output logic      [31:0] rdata        // Logical read data
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] swap32(input logic [31:0] v);
    swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  function automatic logic [3:0] swap4(input logic [3:0] v);
    swap4 = {v[0], v[1], v[2], v[3]};
  endfunction

  // Mirror lanes for big endian
  wire logic [31:0] ord_data = big_endian ? swap32(data_in) : data_in;      // [RL2]
  wire logic [3:0]  ord_be   = big_endian ? swap4(be_in) : be_in;          // [RL2]
  wire logic        hi_half  = low_addr[1] ^ big_endian;
  wire logic [15:0] half_w   = hi_half ? ord_data[31:16] : ord_data[15:0];
  wire logic [1:0]  half_be  = hi_half ? ord_be[3:2] : ord_be[1:0];
  wire logic [1:0]  byte_sel = low_addr ^ {big_endian, big_endian};
  wire logic [7:0]  byte_w   = ord_data[8*byte_sel +: 8];
  wire logic        byte_be  = ord_be[byte_sel];
  logic      [31:0] rd_ord;

  // Place data on lanes by port width; narrow ports zero unused write lanes and repeat their read lanes
  always_comb begin
    data_out = ord_data;
    be_out   = ord_be;
    rd_ord   = pin_data;
    case (port)
      EBL_PORT_SDRAM8: begin                                              // [RL7]
        data_out = {24'h00_0000, byte_w};
        be_out   = {3'h0, byte_be};
        rd_ord   = {4{pin_data[7:0]}};
      end
      EBL_PORT_DRAM16, EBL_PORT_SDRAM16: begin                            // [RL7]
        data_out = {16'h0000, half_w};
        be_out   = {2'h0, half_be};
        rd_ord   = {2{pin_data[15:0]}};
      end
      EBL_PORT_STATIC16: begin                                            // [RL7]
        data_out = {half_w, 16'h0000};
        be_out   = {half_be, 2'h0};
        rd_ord   = {2{pin_data[31:16]}};
      end
      default: begin
        data_out = ord_data;                                              // [RL7]
        be_out   = ord_be;
        rd_ord   = pin_data;
      end
    endcase
  end
  assign rdata = big_endian ? swap32(rd_ord) : rd_ord;                     // [RL2]
endmodule // ebl_lane_steer
`default_nettype wire

// ---- design/ebl_bus_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ebl_consts.svh"
// Operation
// [RL1] Sample endian pin once after reset
// [RL2] Big endian mirrors byte lanes and strobes
// [RL3] DRAM row then column on 13 lines
// [RL4] Static: drive upper bits, pulse latch enable
// [RL5] Then hold low bits until cycle end
// [RL6] Drive data bus except during reads
// [RL7] Lane placement follows port width
// [RL8] Read strobe for all static select spaces
// [RL9] Debug option shows internal reads too
// [RL10] Write strobe for selects and DRAM/SDRAM
// [RL11] Column strobes act as byte write enables
// [RL12] Each general select is 32 or 16 bit
// [RL13] Latch pulse ends before any strobe
module ebl_bus_pins
  import ebl_pkg::*;
(
  input  wire logic        clock,                      // 50 MHz bus clock
  input  wire logic        rstn,                       // Async reset, active low
  input  wire logic        endian_select_pin,          // Low selects big endian
  input  wire logic        internal_cycle_visibility,  // Debug: show own reads
  input  wire logic [3:0]  gen_sel_is16,               // Per general select width
  input  wire logic        req_valid,                  // Request present
  input  wire ebl_req_t    req,                        // Request contents
  input  wire logic [31:0] data_in,                    // Data bus input side
  output logic             req_ready,                  // Idle, may take request
  output logic             done,                       // Access finished pulse
  output logic      [31:0] rdata,                      // Read data, valid with done
  output logic             big_endian,                 // Sampled byte order
  output ebl_pins_t        pins                        // Pin bundle
);
  // ----------------------------------------
  // Endian strap capture
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ALE   = 3'h1,
    ST_GAP   = 3'h2,
    ST_ROW   = 3'h3,
    ST_STRB  = 3'h4,
    ST_TURN  = 3'h5
  } ebl_state_t;

  logic [1:0] strap_q;
  logic [1:0] fill_q;
  logic       strap_done_q;
  logic       big_q;

  // Two stage sync, then one capture once both stages hold the pin;
  // capturing earlier would take the reset value of the synchroniser
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_q      <= 2'h3;
      fill_q       <= 2'h0;
      strap_done_q <= 1'b0;
      big_q        <= 1'b0;
    end else begin
      strap_q <= {strap_q[0], endian_select_pin};
      fill_q  <= {fill_q[0], 1'b1};
      if (!strap_done_q && fill_q[1]) begin                               // [RL1]
        strap_done_q <= 1'b1;
        big_q        <= ~strap_q[1];
      end
    end
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  ebl_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  ebl_req_t   cur_q;
  logic       live_q;
  logic [31:0] rdata_q;
  logic       done_q;
  logic       ready_q;
  ebl_pins_t  pins_q, pins_d;

  wire logic [3:0]  lane_be;
  wire logic [31:0] lane_dout;
  wire logic [31:0] lane_rdata;

  ebl_lane_steer u_lane (
    .big_endian (big_q),
    .port       (cur_q.port),
    .low_addr   (cur_q.addr[1:0]),
    .be_in      (cur_q.be),
    .data_in    (cur_q.wdata),
    .pin_data   (data_in),
    .be_out     (lane_be),
    .data_out   (lane_dout),
    .rdata      (lane_rdata)
  );

  // Decode of the request held in cur_q
  wire logic is_dram   = (cur_q.port == EBL_PORT_DRAM16) ||
                         (cur_q.port == EBL_PORT_SDRAM16) ||
                         (cur_q.port == EBL_PORT_SDRAM8);
  wire logic is_int    = (cur_q.port == EBL_PORT_INTERNAL);
  wire logic sel_space = (cur_q.space != EBL_SP_NONE);
  wire logic rd_show   = !cur_q.write &&
                         ((sel_space && !is_dram) ||                      // [RL8]
                          (is_int && internal_cycle_visibility));         // [RL9]
  wire logic wr_show   = cur_q.write && !is_int && (sel_space || is_dram); // [RL10]
  // General selects of 16-bit width are steered as 16-bit static ports
  wire logic gen16     = (req.space == EBL_SP_GEN) && gen_sel_is16[req.sel]; // [RL12]
  wire ebl_req_t req_fix = gen16 ? ebl_req_t'{write: req.write, port: EBL_PORT_STATIC16,
                                     space: req.space, sel: req.sel,
                                     card_attr: req.card_attr, addr: req.addr,
                                     be: req.be, wdata: req.wdata,
                                     row: req.row, col: req.col} : req;
  wire logic [3:0] sel_dec = 4'h1 << cur_q.sel;

  // Next state and pin values
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    pins_d  = pins_q;
    case (state_q)
      ST_IDLE: begin
        pins_d.ale   = 1'b0;
        pins_d.rd_n  = 1'b1;
        pins_d.we_n  = 1'b1;
        pins_d.cbs_n = 4'hF;
        pins_d.doe_n = 1'b0;                                              // [RL6]
        if (live_q && is_dram) begin
          pins_d.addr = cur_q.row;                                        // [RL3]
          state_d     = ST_ROW;
          cnt_d       = `EBL_GAP_CYC;
        end else if (live_q) begin
          pins_d.addr = cur_q.addr[`EBL_HI_MSB:`EBL_HI_LSB];              // [RL4]
          pins_d.ale  = 1'b1;                                             // [RL4]
          state_d     = ST_ALE;
          cnt_d       = `EBL_ALE_CYC;
        end
      end
      ST_ALE: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          pins_d.ale  = 1'b0;                                             // [RL13]
          pins_d.addr = cur_q.addr[`EBL_LO_MSB:0];                        // [RL5]
          state_d     = ST_GAP;
          cnt_d       = `EBL_GAP_CYC;
        end
      end
      ST_GAP, ST_ROW: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          if (state_q == ST_ROW) pins_d.addr = cur_q.col;                 // [RL3]
          pins_d.rd_n  = ~rd_show;                                        // [RL8] [RL9]
          pins_d.we_n  = ~wr_show;                                        // [RL10]
          pins_d.cbs_n = cur_q.write ? ~lane_be : 4'hF;                   // [RL11] [RL2]
          pins_d.dout  = lane_dout;
          pins_d.doe_n = ~cur_q.write;                                    // [RL6]
          state_d      = ST_STRB;
          cnt_d        = `EBL_STROBE_CYC;
        end
      end
      ST_STRB: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          pins_d.rd_n  = 1'b1;
          pins_d.we_n  = 1'b1;
          pins_d.cbs_n = 4'hF;
          state_d      = ST_TURN;
          cnt_d        = `EBL_TURN_CYC;
        end
      end
      ST_TURN: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          pins_d.doe_n = 1'b0;                                            // [RL6]
          pins_d.msel_n = 4'hF;
          pins_d.gsel_n = 4'hF;
          pins_d.card1_n = 1'b1;
          pins_d.card2_n = 1'b1;
          pins_d.reg_n   = 1'b1;
          state_d      = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (state_q == ST_IDLE && live_q) begin
      pins_d.msel_n  = (cur_q.space == EBL_SP_MEM) ? ~sel_dec : 4'hF;
      pins_d.gsel_n  = (cur_q.space == EBL_SP_GEN) ? ~sel_dec : 4'hF;
      pins_d.card1_n = !((cur_q.space == EBL_SP_CARD) && !cur_q.sel[0]);
      pins_d.card2_n = !((cur_q.space == EBL_SP_CARD) && cur_q.sel[0]);
      pins_d.reg_n   = !((cur_q.space == EBL_SP_CARD) && cur_q.card_attr);
    end
  end

  // Take only on ready, so a request held across done is not taken twice
  wire logic take   = req_valid && ready_q;
  wire logic finish = (state_q == ST_TURN) && (cnt_q == 4'h1);
  wire logic sample = (state_q == ST_STRB) && (cnt_q == 4'h1);

  // Request capture and completion
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      live_q  <= 1'b0;
      cur_q   <= '0;
      done_q  <= 1'b0;
      rdata_q <= `EBL_DATA_RST;
    end else begin
      done_q <= finish;
      if (take) cur_q <= req_fix;
      if (take) live_q <= 1'b1;
      else if (finish) live_q <= 1'b0;
      if (sample && !cur_q.write) rdata_q <= lane_rdata;
    end
  end

  // Pin and state registers; pins come straight from flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      pins_q  <= '{addr: 13'h0000, ale: 1'b0, rd_n: 1'b1, we_n: 1'b1,
                   cbs_n: 4'hF, msel_n: 4'hF, gsel_n: 4'hF, card1_n: 1'b1,
                   card2_n: 1'b1, reg_n: 1'b1, dout: 32'h0000_0000, doe_n: 1'b0};
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pins_q  <= pins_d;
    end
  end

  // Ready is held low while an access is live or before the strap is taken
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ready_q <= 1'b0;
    else       ready_q <= strap_done_q && !live_q && !take && !finish;
  end

  assign req_ready  = ready_q;
  assign done       = done_q;
  assign rdata      = rdata_q;
  assign big_endian = big_q;
  assign pins       = pins_q;
endmodule // ebl_bus_pins
`default_nettype wire

// ---- tb/ebl_chk_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ebl_chk
  import ebl_pkg::*;
(
  input wire logic        clock,                      // Bus clock
  input wire logic        rstn,                       // Async reset, active low
  input wire logic        endian_select_pin,          // Byte order strap
  input wire logic        internal_cycle_visibility,  // Debug visibility
  input wire logic [3:0]  gen_sel_is16,               // General select widths
  input wire logic        req_valid,                  // Request present
  input wire ebl_req_t    req,                        // Request contents
  input wire logic [31:0] data_in,                    // Data bus input
  input wire logic        req_ready,                  // Idle
  input wire logic        done,                       // End of access
  input wire logic [31:0] rdata,                      // Read data
  input wire logic        big_endian,                 // Sampled byte order
  input wire ebl_pins_t   pins                        // Pin bundle
);
  // ----------------------------------------
  // Pin timing checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Latch pulse is exactly two cycles wide
  ale_width_a: assert property ($rose(pins.ale) |-> pins.ale[*2] ##1 !pins.ale)
    else $error("address latch pulse width wrong");
  // No strobe while the latch is still open
  ale_before_strobe_a: assert property (pins.ale |->
    pins.rd_n && pins.we_n && pins.cbs_n == 4'hF)
    else $error("strobe overlaps address latch pulse");
  // Low address bits stand through the access
  addr_hold_a: assert property ($fell(pins.ale) |=> $stable(pins.addr)[*4])
    else $error("low address moved during access");
  // Static access ends a fixed time after the latch
  static_end_a: assert property ($fell(pins.ale) |-> ##5 done)
    else $error("static access length wrong");
  write_len_a: assert property ($fell(pins.we_n) |-> !pins.we_n[*3] ##1 pins.we_n)
    else $error("write strobe length wrong");
  read_len_a: assert property ($fell(pins.rd_n) |-> !pins.rd_n[*3] ##1 pins.rd_n)
    else $error("read strobe length wrong");
  // Bus is driven during writes and only released briefly
  write_drive_a: assert property (!pins.we_n |-> !pins.doe_n)
    else $error("data bus not driven during write");
  release_short_a: assert property ($rose(pins.doe_n) |-> ##[1:6] !pins.doe_n)
    else $error("data bus left floating too long");
  write_lanes_a: assert property (!pins.we_n |-> pins.cbs_n != 4'hF)
    else $error("write without any lane enable");
  // Byte order never changes once running
  endian_hold_a: assert property (req_ready |=> $stable(big_endian))
    else $error("byte order changed while running");

  wr_c: cover property (!pins.we_n);
  rd_c: cover property (!pins.rd_n);
  big_c: cover property (done && big_endian);
endmodule // ebl_chk

bind ebl_bus_pins ebl_chk i_ebl_chk (
  .clock(clock), .rstn(rstn), .endian_select_pin(endian_select_pin),
  .internal_cycle_visibility(internal_cycle_visibility), .gen_sel_is16(gen_sel_is16),
  .req_valid(req_valid), .req(req), .data_in(data_in), .req_ready(req_ready),
  .done(done), .rdata(rdata), .big_endian(big_endian), .pins(pins));
`default_nettype wire

// ---- tb/ebl_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ebl_mem_model
  import ebl_pkg::*;
(
  input  wire logic        clock,    // Bus clock
  input  wire ebl_pins_t   pins,     // Device pins
  output logic      [31:0] data_in,  // Data back to device
  output logic      [12:0] hi_q      // External latch contents
);
  logic [31:0] mem [16];
  logic [31:0] last_q = 32'h0;
  wire  [3:0]  idx    = {hi_q[0], pins.addr[4:2]};
  // External latch, transparent while the pulse is high
  always_latch if (pins.ale) hi_q <= pins.addr;
  // Byte lanes written as their strobes allow
  always @(posedge clock) begin
    if (!pins.we_n)
      for (int i = 0; i < 4; i++)
        if (!pins.cbs_n[i]) mem[idx][8*i+:8] <= pins.dout[8*i+:8];
    if (!pins.rd_n) last_q <= mem[idx];
  end
  // Released bus shows the inverse so stale data never passes
  assign data_in = !pins.rd_n ? mem[idx] : ~last_q;
endmodule // ebl_mem_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ebl_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        strap = 1'b1;
  logic        vis = 1'b0;
  logic [3:0]  is16 = 4'h0;
  logic        req_valid = 1'b0;
  ebl_req_t    req = '0;
  wire  [31:0] data_in;
  wire  [12:0] hi_q;
  logic        req_ready, done, big_endian, rd_seen, we_seen, st;
  logic [31:0] rdata, s_dout;
  logic [12:0] a0, r0, s_addr, prev;
  logic [3:0]  s_cbs;
  logic [11:0] s_sel;
  ebl_pins_t   pins;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  ebl_bus_pins i_ebl_bus_pins (.clock(clock), .rstn(rstn), .endian_select_pin(strap),
    .internal_cycle_visibility(vis), .gen_sel_is16(is16), .req_valid(req_valid), .req(req),
    .data_in(data_in), .req_ready(req_ready), .done(done), .rdata(rdata),
    .big_endian(big_endian), .pins(pins));
  ebl_mem_model i_ebl_mem_model (.clock(clock), .pins(pins), .data_in(data_in), .hi_q(hi_q));

  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  always #10 clock = ~clock;
  // Cuts a hang short well past the few hundred cycles needed
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic do_reset(input logic pin);
    strap = pin;
    rstn = 1'b0;
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    repeat (6) @(negedge clock);
  endtask

  function automatic ebl_req_t mk(logic w, ebl_port_t p, ebl_space_t s, logic [1:0] sel,
    logic [25:0] a, logic [3:0] be, logic [31:0] wd, logic [12:0] r, logic [12:0] c);
    return '{w, p, s, sel, 1'b0, a, be, wd, r, c};
  endfunction

  // One access: hold the request until taken, then watch the pins until done
  task automatic run(input ebl_req_t q);
    int n;
    n = 0;
    {rd_seen, we_seen, st} = 3'h0;
    req = q;
    req_valid = 1'b1;
    // Ready seen at a falling edge means the next rising edge takes it
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      if (pins.ale) a0 = pins.addr;
      if (!st && (pins.cbs_n != 4'hF || !pins.we_n || !pins.rd_n)) begin
        st = 1'b1;
        r0 = prev;
      end
      if (!pins.we_n) {we_seen, s_cbs, s_dout, s_addr} = {1'b1, pins.cbs_n, pins.dout, pins.addr};
      if (!pins.rd_n) rd_seen = 1'b1;
      if (!pins.we_n || !pins.rd_n)
        s_sel = {pins.msel_n, pins.gsel_n, pins.card1_n, pins.card2_n, pins.reg_n, pins.doe_n};
      prev = pins.addr;
      @(negedge clock);
      n++;
    end
    chk("done", 32'h1, 32'(done));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_wr_rd();
    ebl_req_t q;
    run(mk(1'b1, EBL_PORT_STATIC32, EBL_SP_MEM, 2'h0, 26'h2ABC5E8, 4'hF, 32'hA5C30F96, 0, 0));
    chk("wr selects", 32'hEFE, 32'(s_sel));
    chk("upper addr", 32'(13'h155E), 32'(a0));
    chk("latched", 32'(13'h155E), 32'(hi_q));
    chk("low addr", 32'(13'h05E8), 32'(s_addr));
    chk("wr lanes", 32'h0, 32'(s_cbs));
    chk("wr data", 32'hA5C30F96, s_dout);
    for (int s = 0; s < 3; s++) begin
      run(mk(1'b0, EBL_PORT_STATIC32, ebl_space_t'(s), 2'h2, 26'h2ABC5E8, 4'hF, 0, 0, 0));
      chk("rd strobe", 32'h1, 32'(rd_seen));
      chk("rd data", 32'hA5C30F96, rdata);
      chk("rd selects", s == 0 ? 32'hBFF : (s == 1 ? 32'hFBF : 32'hFF7), 32'(s_sel));
    end
    q = mk(1'b0, EBL_PORT_STATIC32, EBL_SP_CARD, 2'h1, 26'h2ABC5E8, 4'hF, 0, 0, 0);
    q.card_attr = 1'b1;
    run(q);
    chk("attr selects", 32'hFF9, 32'(s_sel));
    chk("attr rd data", 32'hA5C30F96, rdata);
    $display("test wr_rd end");
  endtask

  task automatic t_byte(input logic big);
    logic [25:0] a;
    // A fresh word per byte order, so the read back cannot hit old lanes
    a = big ? 26'h0000014 : 26'h0000010;
    run(mk(1'b1, EBL_PORT_STATIC32, EBL_SP_MEM, 2'h1, a, 4'h1, 32'h11223344, 0, 0));
    chk("byte lane", big ? 32'h7 : 32'hE, 32'(s_cbs));
    chk("byte data", 32'h44, big ? 32'(s_dout[31:24]) : 32'(s_dout[7:0]));
    run(mk(1'b0, EBL_PORT_STATIC32, EBL_SP_MEM, 2'h1, a, 4'hF, 0, 0, 0));
    chk("byte read", 32'h44, 32'(rdata[7:0]));
    $display("test byte end");
  endtask

  task automatic t_gen16();
    is16 = 4'h2;
    run(mk(1'b1, EBL_PORT_STATIC32, EBL_SP_GEN, 2'h1, 26'h0000020, 4'h3, 32'h0000BEEF, 0, 0));
    chk("half lanes", 32'h3, 32'(s_cbs));
    chk("half data", 32'hBEEF, 32'(s_dout[31:16]));
    is16 = 4'h0;
    $display("test gen16 end");
  endtask

  task automatic t_dram();
    run(mk(1'b1, EBL_PORT_DRAM16, EBL_SP_NONE, 2'h0, 26'h0, 4'h3, 32'h00005A5A,
      13'h0155, 13'h0AAA));
    chk("row", 32'(13'h0155), 32'(r0));
    chk("col", 32'(13'h0AAA), 32'(s_addr));
    chk("dram we", 32'h1, 32'(we_seen));
    chk("dram lanes", 32'hC, 32'(s_cbs));
    run(mk(1'b1, EBL_PORT_SDRAM8, EBL_SP_NONE, 2'h0, 26'h2, 4'h4, 32'h00CC0000,
      13'h0001, 13'h0002));
    chk("sdram8 lanes", 32'hE, 32'(s_cbs));
    chk("sdram8 data", 32'hCC, 32'(s_dout[7:0]));
    $display("test dram end");
  endtask

  task automatic t_intl();
    for (int v = 0; v < 2; v++) begin
      vis = v[0];
      run(mk(1'b0, EBL_PORT_INTERNAL, EBL_SP_NONE, 2'h0, 26'h40, 4'hF, 0, 0, 0));
      chk("shown rd", 32'(v), 32'(rd_seen));
    end
    vis = 1'b0;
    $display("test intl end");
  endtask

  initial begin
    do_reset(1'b1);
    chk("endian", 32'h0, 32'(big_endian));
    t_wr_rd();
    t_byte(1'b0);
    t_gen16();
    t_dram();
    t_intl();
    do_reset(1'b0);
    strap = 1'b1;
    chk("endian", 32'h1, 32'(big_endian));
    t_byte(1'b1);
    chk("endian", 32'h1, 32'(big_endian));
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
